// ==== logic/pwm_out_stage.sv ====
`timescale 1ns/10ps
module pwm_out_stage
  import timer_pwm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ovf,
  input wire logic match,
  input wire logic drive,
  input chanCtl_s ctl,
  output logic pinOut,
  output logic pinOe
);

  logic out_r;
  logic out_nxt;
  logic [1:0] edgeSel;

  assign edgeSel = {ctl.edgeHi, ctl.edgeLo};

  // Pin level: rollover toggle first, compare forcing after it
  always_comb begin
    out_nxt = out_r;
    // (RULE_16) Held pulse level
    if (ctl.fullDuty && !ctl.tov) begin
      out_nxt = ~ctl.edgeLo;
    end else begin
      // (RULE_15) No toggle with tov off
      // (RULE_22) Toggle at rollover
      if (ovf && ctl.tov) begin
        out_nxt = ~out_nxt;
      end
      // (RULE_13) Compare action select
      if (match) begin
        case (edgeSel)
          EDGE_CLEAR: out_nxt = 1'b0;
          EDGE_SET: out_nxt = 1'b1;
          EDGE_TOGGLE: out_nxt = ~out_nxt;
          default: out_nxt = out_nxt;
        endcase
      end
    end
  end

  // Pin register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign pinOut = out_r;
  assign pinOe = drive && (edgeSel != 2'h0);

endmodule

// ==== logic/timer_pwm_channels.sv ====
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
// Contract
// (RULE_01) Any channel does unbuffered PWM by overwriting its compare value.
// (RULE_02) Compare happens only on an exact counter match.
// (RULE_03) Software shortens a pulse inside the compare interrupt.
// (RULE_04) Software lengthens a pulse inside the rollover interrupt.
// (RULE_05) Software never selects toggle-on-compare for PWM.
// (RULE_06) Channel 0 buffer select pairs 0/1 on pin 0, ch0 first.
// (RULE_07) Last written compare of the pair governs from next rollover.
// (RULE_08) Channel 0 control runs the pair; channel 1 pin is freed.
// (RULE_09) Channel 2 buffer select pairs 2/3 the same way.
// (RULE_10) Software never rewrites the active compare of a pair.
// (RULE_11) Setup: halt, reset, period, width, channel setup, run.
// (RULE_12) Mode pair 0:1 unbuffered, 1:0 buffered.
// (RULE_13) Edge pair 1:0 clears, 1:1 sets output on compare.
// (RULE_14) Upper mode bit of channels 0 and 2 beats lower bit.
// (RULE_15) Rollover toggle off gives 0% duty.
// (RULE_16) Full duty bit with toggle off gives 100% duty.
// (RULE_17) Rollover flag sets at wrap; interrupt only when enabled.
// (RULE_18) Channel flag sets on compare; interrupt only when enabled.
// (RULE_19) Wait mode: timer runs, registers closed, interrupts wake.
// (RULE_20) Software halts the timer before wait if unneeded.
// (RULE_21) Stop mode halts the timer, keeping all state.
// (RULE_22) Period is the time between rollovers; toggle at rollover.
module timer_pwm_channels
  import timer_pwm_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PS_STAGES = 6
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic waitMode,
  input wire logic stopMode,
  output logic timerIrq,
  output logic [3:0] chPinOut,
  output logic [3:0] chPinOe
);

  localparam int NCH = 4;

  // Elaboration checks
  if (CNT_W < 8 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W must be 8 to 16");
  end
  if (PS_STAGES != 6) begin : g_bad_ps
    $error("PS_STAGES must be 6");
  end

  ////////////////////////////////////////////////////////////////////
  // State

  logic tof_r, tof_nxt;
  logic rollover_irq_enable_r, rollover_irq_enable_nxt;
  logic halt_r, halt_nxt;
  logic [PS_W-1:0] ps_r, ps_nxt;
  logic [CNT_W-1:0] mod_r, mod_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [PS_STAGES-1:0] psCnt_r, psCnt_nxt;
  chanCtl_s chCtl_r [NCH];
  chanCtl_s chCtl_nxt [NCH];
  logic [CNT_W-1:0] chCmp_r [NCH];
  logic [CNT_W-1:0] chCmp_nxt [NCH];
  logic [1:0] actSel_r, actSel_nxt;
  logic [1:0] lastWr_r, lastWr_nxt;
  logic wrPend_r, wrPend_nxt;
  logic [7:0] wrAddr_r, wrAddr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;

  logic take, run, tick, ovf, trstWr;
  logic [PS_STAGES-1:0] psMask;
  logic [1:0] linked;
  logic [NCH-1:0] chOn, chMatch, chDrive, cmpWr;
  logic [CNT_W-1:0] effCmp [NCH];

  ////////////////////////////////////////////////////////////////////
  // Bus and counter timing

  // Address phase taken only while the registers are open
  // (RULE_19) Closed in wait mode
  assign take = hsel && hready && htrans[1] && !waitMode;
  // Zero wait states: every transfer is answered at once
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // (RULE_21) Counting halts in stop mode
  assign run = !halt_r && !stopMode;
  assign psMask = PS_STAGES'((7'h1 << ps_r) - 7'h1);
  assign tick = run && !trstWr && (ps_r != PS_EXT) &&
    ((psCnt_r & psMask) == psMask);
  // (RULE_17) Wrap after matching modulo
  assign ovf = tick && (cnt_r == mod_r);
  // (RULE_09) Pair 2/3 built as pair 0/1
  // (RULE_14) Upper bit alone decides pairing
  assign linked = {chCtl_r[2].modeHi, chCtl_r[0].modeHi};
  // Counter reset beats a tick in the same cycle
  assign trstWr = wrPend_r && (wrAddr_r == OFS_TSC) && hwdata[TSC_RST];

  ////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam int P = i / 2;
    localparam bit ODD = (i % 2) == 1;
    if (ODD) begin : g_odd
      // (RULE_08) Second channel idle while paired
      assign chOn[i] = !linked[P] && chCtl_r[i].modeLo;
      assign effCmp[i] = chCmp_r[i];
    end else begin : g_even
      // (RULE_12) Either mode code enables
      assign chOn[i] = chCtl_r[i].modeHi || chCtl_r[i].modeLo;
      // (RULE_06) Active register of the pair
      assign effCmp[i] = (linked[P] && actSel_r[P]) ?
        chCmp_r[i+1] : chCmp_r[i];
    end
    // (RULE_02) Exact match only
    assign chMatch[i] = tick && chOn[i] && (cnt_r == effCmp[i]);
    assign chDrive[i] = chOn[i];
    pwm_out_stage u_out (
      .ref_clk(ref_clk),
      .rst(rst),
      .ovf(ovf),
      .match(chMatch[i]),
      .drive(chDrive[i]),
      .ctl(chCtl_r[i]),
      .pinOut(chPinOut[i]),
      .pinOe(chPinOe[i])
    );
  end

  // (RULE_18) Interrupt request gated by enables
  always_comb begin
    timerIrq = tof_r && rollover_irq_enable_r;
    for (int i = 0; i < NCH; i++) begin
      timerIrq = timerIrq || (chCtl_r[i].flag && chCtl_r[i].irqEn);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0] a;
    a = haddr[7:0];
    tof_nxt = tof_r;
    rollover_irq_enable_nxt = rollover_irq_enable_r;
    halt_nxt = halt_r;
    ps_nxt = ps_r;
    mod_nxt = mod_r;
    cnt_nxt = cnt_r;
    psCnt_nxt = psCnt_r;
    chCtl_nxt = chCtl_r;
    chCmp_nxt = chCmp_r;
    actSel_nxt = actSel_r;
    lastWr_nxt = lastWr_r;
    cmpWr = '0;
    wrPend_nxt = take && hwrite;
    wrAddr_nxt = take ? a : wrAddr_r;
    hrdata_nxt = '0;

    // Read data prepared in the address phase
    if (take && !hwrite) begin
      if (a == OFS_TSC) begin
        hrdata_nxt[TSC_FLAG] = tof_r;
        hrdata_nxt[TSC_IRQEN] = rollover_irq_enable_r;
        hrdata_nxt[TSC_HALT] = halt_r;
        hrdata_nxt[TSC_PS_LO +: PS_W] = ps_r;
      end else if (a == OFS_CNT) begin
        hrdata_nxt[CNT_W-1:0] = cnt_r;
      end else if (a == OFS_MOD) begin
        hrdata_nxt[CNT_W-1:0] = mod_r;
      end
      for (int i = 0; i < NCH; i++) begin
        if (a == OFS_CHSC0 + 8'(i) * CH_STRIDE) begin
          hrdata_nxt[7:0] = chCtl_r[i];
        end
        if (a == OFS_CHCMP0 + 8'(i) * CH_STRIDE) begin
          hrdata_nxt[CNT_W-1:0] = chCmp_r[i];
        end
      end
    end

    // Data phase writes; flags clear only by writing zero
    if (wrPend_r) begin
      if (wrAddr_r == OFS_TSC) begin
        tof_nxt = tof_r && hwdata[TSC_FLAG];
        rollover_irq_enable_nxt = hwdata[TSC_IRQEN];
        halt_nxt = hwdata[TSC_HALT];
        ps_nxt = hwdata[TSC_PS_LO +: PS_W];
      end else if (wrAddr_r == OFS_MOD) begin
        mod_nxt = hwdata[CNT_W-1:0];
      end
      for (int i = 0; i < NCH; i++) begin
        if (wrAddr_r == OFS_CHSC0 + 8'(i) * CH_STRIDE) begin
          chCtl_nxt[i] = hwdata[7:0];
          chCtl_nxt[i].flag = chCtl_r[i].flag && hwdata[7];
        end
        // (RULE_01) Compare value overwritten directly
        if (wrAddr_r == OFS_CHCMP0 + 8'(i) * CH_STRIDE) begin
          chCmp_nxt[i] = hwdata[CNT_W-1:0];
          cmpWr[i] = 1'b1;
        end
      end
    end

    // Counter and prescaler
    if (trstWr) begin
      cnt_nxt = '0;
      psCnt_nxt = '0;
    end else if (run) begin
      psCnt_nxt = psCnt_r + PS_STAGES'(1);
      if (ovf) begin
        cnt_nxt = '0;
      end else if (tick) begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end

    // (RULE_17) Set wins over a clearing write
    if (ovf) begin
      tof_nxt = 1'b1;
    end
    // (RULE_18) Channel flag on compare
    for (int i = 0; i < NCH; i++) begin
      if (chMatch[i]) begin
        chCtl_nxt[i].flag = 1'b1;
      end
    end

    // (RULE_07) Pair handover at rollover
    for (int p = 0; p < 2; p++) begin
      if (!linked[p]) begin
        lastWr_nxt[p] = 1'b0;
        actSel_nxt[p] = 1'b0;
      end else begin
        if (cmpWr[2*p+1]) begin
          lastWr_nxt[p] = 1'b1;
        end else if (cmpWr[2*p]) begin
          lastWr_nxt[p] = 1'b0;
        end
        if (ovf) begin
          actSel_nxt[p] = lastWr_nxt[p];
        end
      end
    end
  end

  // Registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tof_r <= 1'b0;
      rollover_irq_enable_r <= 1'b0;
      halt_r <= 1'b1;
      ps_r <= '0;
      mod_r <= MOD_RESET[CNT_W-1:0];
      cnt_r <= '0;
      psCnt_r <= '0;
      for (int i = 0; i < NCH; i++) begin
        chCtl_r[i] <= CHSC_RESET;
        chCmp_r[i] <= '0;
      end
      actSel_r <= '0;
      lastWr_r <= '0;
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
      hrdata_r <= '0;
    end else begin
      tof_r <= tof_nxt;
      rollover_irq_enable_r <= rollover_irq_enable_nxt;
      halt_r <= halt_nxt;
      ps_r <= ps_nxt;
      mod_r <= mod_nxt;
      cnt_r <= cnt_nxt;
      psCnt_r <= psCnt_nxt;
      chCtl_r <= chCtl_nxt;
      chCmp_r <= chCmp_nxt;
      actSel_r <= actSel_nxt;
      lastWr_r <= lastWr_nxt;
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_wrap_flag: assert property ( // (RULE_17)
    ovf |=> tof_r && cnt_r == '0
  ) else $error("rollover did not wrap and flag");

  a_stop_hold: assert property ( // (RULE_21)
    stopMode && !trstWr |=> cnt_r == $past(cnt_r)
  ) else $error("counter moved in stop mode");

  a_wait_closed: assert property ( // (RULE_19)
    waitMode && hsel && htrans[1] && hwrite |=> !wrPend_r
  ) else $error("write taken in wait mode");

  a_chan_flag: assert property ( // (RULE_18)
    chMatch[0] |=> chCtl_r[0].flag &&
      (timerIrq || !chCtl_r[0].irqEn)
  ) else $error("channel flag missed compare");

  a_freed_pin: assert property ( // (RULE_08)
    linked[0] |-> !chPinOe[1] && !chMatch[1]
  ) else $error("paired channel 1 still active");

  a_pair_swap: assert property ( // (RULE_07)
    linked[1] && ovf && !cmpWr[2] && !cmpWr[3] |=>
      actSel_r[1] == $past(lastWr_r[1])
  ) else $error("pair did not hand over");

  a_full_duty: assert property ( // (RULE_16)
    (chCtl_r[0].fullDuty && !chCtl_r[0].tov && !chCtl_r[0].edgeLo)
      [*2] |-> chPinOut[0]
  ) else $error("full duty output not held");

  a_zero_duty: assert property ( // (RULE_15)
    !chCtl_r[0].tov && !chCtl_r[0].fullDuty && !chPinOut[0] &&
      {chCtl_r[0].edgeHi, chCtl_r[0].edgeLo} == EDGE_CLEAR
      |=> !chPinOut[0]
  ) else $error("zero duty output rose");

  a_exact_match: assert property ( // (RULE_02)
    chMatch[2] |-> cnt_r == effCmp[2] && tick
  ) else $error("compare without match");

endmodule

// ==== logic/timer_pwm_pkg.sv ====
package timer_pwm_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_TSC = 8'h00;
  localparam logic [7:0] OFS_CNT = 8'h04;
  localparam logic [7:0] OFS_MOD = 8'h08;
  localparam logic [7:0] OFS_CHSC0 = 8'h10;
  localparam logic [7:0] OFS_CHCMP0 = 8'h14;
  localparam logic [7:0] CH_STRIDE = 8'h08;

  // Timer status/control field positions
  localparam int TSC_FLAG = 7;
  localparam int TSC_IRQEN = 6;
  localparam int TSC_HALT = 5;
  localparam int TSC_RST = 4;
  localparam int TSC_PS_LO = 0;
  localparam int PS_W = 3;

  // Modulo reset value and the prescaler code that gives no count ticks
  localparam logic [15:0] MOD_RESET = 16'hffff;
  localparam logic [PS_W-1:0] PS_EXT = 3'h7;

  // Channel mode and edge/level encodings
  localparam logic [1:0] MODE_UNBUF = 2'h1;
  localparam logic [1:0] MODE_BUF = 2'h2;
  localparam logic [1:0] EDGE_TOGGLE = 2'h1;
  localparam logic [1:0] EDGE_CLEAR = 2'h2;
  localparam logic [1:0] EDGE_SET = 2'h3;

  // Channel status/control, bit 7 down to bit 0
  typedef struct packed {
    logic flag;
    logic irqEn;
    logic modeHi;
    logic modeLo;
    logic edgeHi;
    logic edgeLo;
    logic tov;
    logic fullDuty;
  } chanCtl_s;

  localparam chanCtl_s CHSC_RESET = '0;

endpackage

// ==== tb/pwm_pin_watch.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
// Far-side pin load: counts driven-high cycles in a window
module pwm_pin_watch (
  input wire logic ref_clk,
  input wire logic pin,
  input wire logic oe,
  input wire logic run,
  output int highCnt
);
  // Window counter, cleared while the window is shut
  always @(posedge ref_clk) begin
    if (!run) begin
      highCnt <= 0;
    end else if (pin === 1'b1 && oe === 1'b1) begin
      highCnt <= highCnt + 1;
    end
  end
endmodule

// ==== tb/timer_pwm_channels_bench.sv ====
`timescale 1ns/10ps
module timer_pwm_channels_bench;
  import timer_pwm_pkg::*;
  localparam int PER = 10;
  logic ref_clk = 0;
  logic rst = 1;
  logic hsel = 0;
  logic hwrite = 0;
  logic waitMode = 0;
  logic stopMode = 0;
  logic run = 0;
  logic rdPhase = 0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [1:0] sel = '0;
  logic hready, hresp, timerIrq;
  logic [3:0] chPinOut, chPinOe;
  logic [31:0] expQ[$];
  int num_errors = 0;
  int n_tests = 0;
  int highCnt, w;

  always #50 ref_clk = ~ref_clk;

  timer_pwm_channels i_timer_pwm_channels (.ref_clk, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready), .hresp,
    .hrdata, .waitMode, .stopMode, .timerIrq, .chPinOut, .chPinOe);
  pwm_pin_watch i_pwm_pin_watch (.ref_clk, .pin(chPinOut[sel]),
    .oe(chPinOe[sel]), .run, .highCnt);

  ////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask

  // Bounded wait for the interrupt request
  task automatic wait_irq;
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (timerIrq !== 1'b1 && k < 4 * PER);
    if (timerIrq !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask

  // One single-word transfer, address then data phase
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    rdPhase <= !wr;
    wait_rdy();
    rdPhase <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  // Halt, reset, period, width, setup, run
  task automatic setup(input logic [7:0] ch, input logic [15:0] wd,
                       input logic [7:0] cfg);
    wr(OFS_TSC, 32'h30);
    wr(OFS_MOD, 32'(PER - 1));
    wr(OFS_CHCMP0 + ch * CH_STRIDE, {16'h0, wd});
    wr(OFS_CHSC0 + ch * CH_STRIDE, {24'h0, cfg});
    wr(OFS_TSC, 32'h0);
  endtask

  // Settle three periods, then count high cycles over np periods
  task automatic measure(input logic [1:0] s, input int np,
                         input logic [31:0] e);
    sel <= s;
    repeat (3 * PER) @(posedge ref_clk);
    run <= 1'b1;
    repeat (np * PER) @(posedge ref_clk);
    run <= 1'b0;
    #1;
    check("highCnt", highCnt, e);
  endtask

  ////////////////////////////////////////////////////////////////
  // Read data monitor, oldest note first
  always @(posedge ref_clk) begin
    if (rdPhase && expQ.size() > 0) begin
      check("hrdata", hrdata, expQ.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h7d68d667));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_TSC, 32'h20);
    rd(OFS_MOD, 32'hffff);
    rd(OFS_CHSC0, 32'h0);
    rd(8'hfc, 32'h0);
    // Every channel, both polarities, random width
    // Clear or set, never toggle
    for (int i = 0; i < 4; i++) begin
      w = $urandom_range(8);
      setup(8'(i), 16'(w), 8'h1a);
      measure(2'(i), 4, 32'(4 * (w + 1)));
      setup(8'(i), 16'(w), 8'h1e);
      measure(2'(i), 4, 32'(4 * (PER - 1 - w)));
    end
    // Unsynchronised rewrite recovers within three periods
    setup(8'h0, 16'h2, 8'h1a);
    wr(OFS_CHCMP0, 32'h6);
    measure(2'h0, 4, 32'h1c);
    setup(8'h0, 16'h4, 8'h18);
    measure(2'h0, 4, 32'h0);
    setup(8'h0, 16'h4, 8'h19);
    measure(2'h0, 4, 32'(4 * PER));
    setup(8'h0, 16'h2, 8'h1a);
    wr(OFS_TSC, 32'h40);
    wait_irq();
    wr(OFS_CHCMP0, 32'h6);
    measure(2'h0, 4, 32'h1c);
    wr(OFS_TSC, 32'h0);
    wr(OFS_CHSC0, 32'h5a);
    wait_irq();
    wr(OFS_CHCMP0, 32'h2);
    measure(2'h0, 4, 32'hc);
    // Linked pair 0/1, both mode bits set
    setup(8'h0, 16'h2, 8'h3a);
    check("chPinOe", chPinOe & 4'h3, 4'h1);
    measure(2'h0, 4, 32'hc);
    wr(OFS_CHCMP0 + CH_STRIDE, 32'h6);
    measure(2'h0, 4, 32'h1c);
    wr(OFS_CHCMP0, 32'h1);
    measure(2'h0, 4, 32'h8);
    // Linked pair 2/3
    setup(8'h2, 16'h3, 8'h2a);
    check("chPinOe", chPinOe, 4'h5);
    measure(2'h2, 4, 32'h10);
    wr(OFS_CHCMP0 + 3 * CH_STRIDE, 32'h5);
    measure(2'h2, 4, 32'h18);
    // Flags and the combined request; writing a one keeps the flag
    wr(OFS_TSC, 32'hc0);
    rd(OFS_TSC, 32'hc0);
    check("timerIrq", timerIrq, 1'b1);
    wr(OFS_TSC, 32'h60);
    wr(OFS_TSC, 32'h20);
    rd(OFS_TSC, 32'h20);
    check("timerIrq", timerIrq, 1'b0);
    wr(OFS_CHSC0, 32'hfa);
    rd(OFS_CHSC0, 32'hfa);
    check("timerIrq", timerIrq, 1'b1);
    wr(OFS_CHSC0, 32'h3a);
    #1;
    check("timerIrq", timerIrq, 1'b0);
    // Wait mode: bus closed, timer runs, request wakes
    // Timer kept running to wake
    wr(OFS_TSC, 32'h40);
    @(posedge ref_clk) waitMode <= 1'b1;
    wr(OFS_MOD, 32'h5);
    rd(OFS_MOD, 32'h0);
    repeat (2 * PER) @(posedge ref_clk);
    check("timerIrq", timerIrq, 1'b1);
    @(posedge ref_clk) waitMode <= 1'b0;
    rd(OFS_MOD, 32'(PER - 1));
    // Stop mode freezes the counter and keeps state
    wr(OFS_TSC, 32'h30);
    @(posedge ref_clk) stopMode <= 1'b1;
    wr(OFS_TSC, 32'h0);
    repeat (2 * PER) @(posedge ref_clk);
    rd(OFS_CNT, 32'h0);
    rd(OFS_MOD, 32'(PER - 1));
    @(posedge ref_clk) stopMode <= 1'b0;
    repeat (3) @(posedge ref_clk);
    results();
  end
endmodule
